// ---- rtl/lcs_cfg.svh ----
// loop check supervisor: offsets, pass threshold, reset values, timing counts
// assumes a 100 MHz core clock and a four-channel detector
//
// Summary of operation
// - a channel's loop check runs only while its interval setting is 1 to 255 minutes.
// - an interval of zero switches the check off and no check test is made.
// - when the interval runs out the check loop of that channel is shorted to simulate a vehicle.
// - a change at or above the pass threshold is a pass, shown as the pass screen on the selected channel.
// - a change below threshold starts verification with a flashing pending screen for at most 55 s.
// - a failed verification flashes the channel's indicator at three flashes per second.
// - the selected failed channel alternates two fail screens with equal on and off times.
// - a check failure forces the channel's detection output to call and its health flag to fail.
// - a check failure drops every primary vital output the channel's detection or health is mapped to.
// - a check failure drops the auxiliary vital output when the channel's health is mapped to it.
// - a latched failure clears on a zero interval, on power-up, or on a reset of that channel.
// - clearing does not hide the fault: the next scheduled check fails again on a bad loop.
// - no check test runs while the loop has an open, shorted or large relative change failure.
// - every enabled channel without a loop failure is checked two seconds after its interval is set from zero or after a reset of that channel.
`ifndef LCS_CFG_SVH
`define LCS_CFG_SVH
`define LCS_CH_N 4
`define LCS_CLK_MHZ 100
`define LCS_TICK_MS 10
`define LCS_TICK_CYC (`LCS_TICK_MS * 1000 * `LCS_CLK_MHZ)
`define LCS_SEC_TICKS (1000 / `LCS_TICK_MS)
`define LCS_FLASH_HZ 3
`define LCS_FLASH_TICKS (1000 / (2 * `LCS_FLASH_HZ * `LCS_TICK_MS))
`define LCS_ALT_MS 500
`define LCS_ALT_TICKS (`LCS_ALT_MS / `LCS_TICK_MS)
`define LCS_VERIFY_S 55
`define LCS_VERIFY_TICKS (`LCS_VERIFY_S * `LCS_SEC_TICKS)
`define LCS_BOOT_S 2
`define LCS_BOOT_TICKS (`LCS_BOOT_S * `LCS_SEC_TICKS)
`define LCS_MIN_S 14'd60
`define LCS_PASS_THRESH 16'h0028
`define LCS_A_IVAL 8'h00
`define LCS_A_DISP 8'h04
`define LCS_A_STAT 8'h08
`define LCS_A_IRQ 8'h0c
`define LCS_A_MASK 8'h10
`define LCS_A_MAP 8'h14
`define LCS_A_CRST 8'h18
`define LCS_IVAL_RST 32'h00000000
`define LCS_MAP_RST 12'h000
`endif

// ---- rtl/lcs_pkg.sv ----
// loop check supervisor types
// assumes lcs_cfg.svh on the include path
`include "lcs_cfg.svh"
package lcs_pkg;
   typedef enum logic [5:0] {
      LCS_OFF = 6'h01, LCS_BOOT = 6'h02, LCS_WAIT = 6'h04,
      LCS_MEAS = 6'h08, LCS_VER = 6'h10, LCS_FAIL = 6'h20
   } lcs_st_type;
   typedef enum logic [2:0] {
      LCS_SCR_NONE = 3'h0, LCS_SCR_PASS = 3'h1, LCS_SCR_PEND = 3'h2,
      LCS_SCR_FAIL_L = 3'h3, LCS_SCR_FAIL_LC = 3'h4
   } lcs_scr_type;
endpackage : lcs_pkg

// ---- rtl/lcs_time_if.sv ----
// slow timebase carrier between the timebase and the supervisor core
// assumes a single core clock domain
`timescale 1ns/1ps
interface lcs_time_if;
   logic tick;
   logic tick_sec;
   logic ph_flash;
   logic ph_alt;
   modport src (output tick, output tick_sec, output ph_flash, output ph_alt);
   modport snk (input tick, input tick_sec, input ph_flash, input ph_alt);
endinterface : lcs_time_if

// ---- rtl/lcs_timebase.sv ----
// slow tick, seconds tick and flash phases for the supervisor
// assumes core_clk at the configured rate, synchronous reset
`timescale 1ns/1ps
module lcs_timebase import lcs_pkg::*; #(
   parameter int unsigned TICK_CYC = `LCS_TICK_CYC
) (
   input wire logic core_clk,
   input wire logic rst,
   lcs_time_if.src tb
);
   typedef struct packed {
      logic [31:0] div;
      logic [7:0] sec;
      logic [7:0] fl;
      logic [7:0] alt;
      logic tick;
      logic tsec;
      logic phf;
      logic pha;
   } lcs_tb_type;
   lcs_tb_type s_q, s_d;

   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      s_d.tsec = 1'b0;
      if (s_q.div == TICK_CYC - 1) begin
         s_d.div = 32'h0;
         s_d.tick = 1'b1;
         s_d.sec = (s_q.sec == 8'(`LCS_SEC_TICKS - 1)) ? 8'h00 : s_q.sec + 8'h01;
         s_d.tsec = (s_q.sec == 8'(`LCS_SEC_TICKS - 1));
         // 3 Hz half period rounds down, so the flash runs a touch fast
         if (s_q.fl == 8'(`LCS_FLASH_TICKS - 1)) begin
            s_d.fl = 8'h00;
            s_d.phf = ~s_q.phf;
         end else begin
            s_d.fl = s_q.fl + 8'h01;
         end
         if (s_q.alt == 8'(`LCS_ALT_TICKS - 1)) begin
            s_d.alt = 8'h00;
            s_d.pha = ~s_q.pha;
         end else begin
            s_d.alt = s_q.alt + 8'h01;
         end
      end else begin
         s_d.div = s_q.div + 32'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tb.tick = s_q.tick;
   assign tb.tick_sec = s_q.tsec;
   assign tb.ph_flash = s_q.phf;
   assign tb.ph_alt = s_q.pha;
endmodule : lcs_timebase

// ---- rtl/lcs_vital_map.sv ----
// vital output gating from per-channel failures and mapping masks
// assumes masks and failures are next-state values; the caller registers the outputs
`timescale 1ns/1ps
module lcs_vital_map import lcs_pkg::*; (
   input wire logic [`LCS_CH_N-1:0] fail,
   input wire logic [`LCS_CH_N-1:0] det_map,
   input wire logic [`LCS_CH_N-1:0] hlth_map,
   input wire logic [`LCS_CH_N-1:0] aux_map,
   input wire logic pri_in,
   input wire logic aux_in,
   output logic pri_out,
   output logic aux_out
);
   always_comb begin
      pri_out = pri_in & ~|(fail & (det_map | hlth_map));
      aux_out = aux_in & ~|(fail & aux_map);
   end
endmodule : lcs_vital_map

// ---- rtl/lcs_top.sv ----
// loop check supervisor: per-channel check scheduling, verification, failure latch
// assumes the front end reports one measurement per valid pulse while the check loop is shorted
`timescale 1ns/1ps
module lcs_top import lcs_pkg::*; #(
   parameter int unsigned TICK_CYC = `LCS_TICK_CYC
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic [`LCS_CH_N-1:0] loop_fault,
   input wire logic [`LCS_CH_N-1:0] meas_valid,
   input wire logic [`LCS_CH_N*16-1:0] meas_mag,
   input wire logic [`LCS_CH_N-1:0] det_call_in,
   input wire logic vital_pri_in,
   input wire logic vital_aux_in,
   output logic [`LCS_CH_N-1:0] check_short,
   output logic [`LCS_CH_N-1:0] det_call,
   output logic [`LCS_CH_N-1:0] health_ok,
   output logic [`LCS_CH_N-1:0] chan_led,
   output logic vital_pri,
   output logic vital_aux,
   output lcs_scr_type disp_screen,
   output logic irq
);
   localparam int CN = `LCS_CH_N;

   typedef struct packed {
      lcs_st_type [CN-1:0] st;
      logic [CN-1:0][13:0] cnt;
      logic [CN-1:0][7:0] ival;
      logic [CN-1:0] passed;
      logic [1:0] sel;
      logic [CN-1:0] det_map;
      logic [CN-1:0] hlth_map;
      logic [CN-1:0] aux_map;
      logic [2*CN-1:0] stat;
      logic [2*CN-1:0] mask;
      logic [31:0] rdata;
      logic [CN-1:0] short;
      logic [CN-1:0] call;
      logic [CN-1:0] hok;
      logic [CN-1:0] led;
      logic vpri;
      logic vaux;
      lcs_scr_type scr;
      logic irq;
   } lcs_state_type;

   lcs_state_type s_q, s_d;
   lcs_time_if tb ();
   logic [CN-1:0] fail_d;
   logic [CN-1:0] crst;
   logic pri_ok, aux_ok;

   lcs_timebase #(.TICK_CYC(TICK_CYC)) u_tb (
      .core_clk(core_clk),
      .rst(rst),
      .tb(tb.src)
   );

   lcs_vital_map u_map (
      .fail(fail_d),
      .det_map(s_d.det_map),
      .hlth_map(s_d.hlth_map),
      .aux_map(s_d.aux_map),
      .pri_in(vital_pri_in),
      .aux_in(vital_aux_in),
      .pri_out(pri_ok),
      .aux_out(aux_ok)
   );

   always_comb begin
      lcs_state_type n;
      logic [15:0] mag;
      logic go;
      logic [2*CN-1:0] ev;
      logic [13:0] reload;
      n = s_q;
      mag = 16'h0;
      go = 1'b0;
      ev = '0;
      reload = 14'h0;
      crst = '0;
      // register writes
      if (reg_wr) begin
         if (reg_addr == `LCS_A_IVAL) begin
            n.ival = reg_wdata[8*CN-1:0];
         end else if (reg_addr == `LCS_A_DISP) begin
            n.sel = reg_wdata[1:0];
         end else if (reg_addr == `LCS_A_MASK) begin
            n.mask = reg_wdata[2*CN-1:0];
         end else if (reg_addr == `LCS_A_MAP) begin
            n.det_map = reg_wdata[CN-1:0];
            n.hlth_map = reg_wdata[2*CN-1:CN];
            n.aux_map = reg_wdata[3*CN-1:2*CN];
         end else if (reg_addr == `LCS_A_CRST) begin
            crst = reg_wdata[CN-1:0];
         end
      end
      // channel sequencers
      for (int i = 0; i < CN; i++) begin
         mag = meas_mag[16*i +: 16];
         reload = 14'(s_q.ival[i] * `LCS_MIN_S);
         unique case (s_q.st[i])
            LCS_OFF: begin
               if (s_q.ival[i] != 8'h00) begin
                  n.st[i] = LCS_BOOT;
                  n.cnt[i] = 14'(`LCS_BOOT_TICKS);
               end
            end
            LCS_BOOT, LCS_WAIT: begin
               go = 1'b0;
               if (s_q.st[i] == LCS_BOOT && tb.tick) begin
                  go = (s_q.cnt[i] == 14'h0);
                  n.cnt[i] = go ? 14'h0 : s_q.cnt[i] - 14'h1;
               end else if (s_q.st[i] == LCS_WAIT && tb.tick_sec) begin
                  go = (s_q.cnt[i] <= 14'h1);
                  n.cnt[i] = go ? 14'h0 : s_q.cnt[i] - 14'h1;
               end
               if (go && loop_fault[i]) begin
                  n.st[i] = LCS_WAIT;
                  n.cnt[i] = reload;
               end else if (go) begin
                  n.st[i] = LCS_MEAS;
                  n.passed[i] = 1'b0;
               end
            end
            LCS_MEAS, LCS_VER: begin
               if (loop_fault[i]) begin
                  n.st[i] = LCS_WAIT;
                  n.cnt[i] = reload;
               end else if (meas_valid[i] && mag >= `LCS_PASS_THRESH) begin
                  n.st[i] = LCS_WAIT;
                  n.cnt[i] = reload;
                  n.passed[i] = 1'b1;
                  ev[i] = 1'b1;
               end else if (s_q.st[i] == LCS_MEAS) begin
                  if (meas_valid[i]) begin
                     n.st[i] = LCS_VER;
                     n.cnt[i] = 14'(`LCS_VERIFY_TICKS);
                  end
               end else if (tb.tick) begin
                  if (s_q.cnt[i] <= 14'h1) begin
                     n.st[i] = LCS_FAIL;
                     n.cnt[i] = reload;
                     ev[CN+i] = 1'b1;
                  end else begin
                     n.cnt[i] = s_q.cnt[i] - 14'h1;
                  end
               end
            end
            default: begin
               n.st[i] = LCS_FAIL;
            end
         endcase
         // a zero interval or a channel reset overrides the sequence
         if (n.ival[i] == 8'h00) begin
            n.st[i] = LCS_OFF;
            n.passed[i] = 1'b0;
         end else if (crst[i]) begin
            n.st[i] = LCS_BOOT;
            n.cnt[i] = 14'(`LCS_BOOT_TICKS);
            n.passed[i] = 1'b0;
         end
         fail_d[i] = (n.st[i] == LCS_FAIL);
         n.short[i] = (n.st[i] == LCS_MEAS) || (n.st[i] == LCS_VER);
         n.call[i] = det_call_in[i] | fail_d[i];
         n.hok[i] = ~fail_d[i];
         n.led[i] = fail_d[i] ? tb.ph_flash : det_call_in[i];
      end
      // hardware set wins over a write-one clear
      if (reg_wr && reg_addr == `LCS_A_IRQ) begin
         n.stat = s_q.stat & ~reg_wdata[2*CN-1:0];
      end
      n.stat = n.stat | ev;
      n.irq = |(n.stat & n.mask);
      // display for the selected channel
      if (n.st[n.sel] == LCS_FAIL) begin
         n.scr = tb.ph_alt ? LCS_SCR_FAIL_LC : LCS_SCR_FAIL_L;
      end else if (n.st[n.sel] == LCS_VER) begin
         n.scr = tb.ph_alt ? LCS_SCR_PEND : LCS_SCR_NONE;
      end else if (n.passed[n.sel]) begin
         n.scr = LCS_SCR_PASS;
      end else begin
         n.scr = LCS_SCR_NONE;
      end
      // read data stands only in the cycle after the strobe
      n.rdata = 32'h0;
      if (reg_rd) begin
         if (reg_addr == `LCS_A_IVAL) begin
            n.rdata[8*CN-1:0] = s_q.ival;
         end else if (reg_addr == `LCS_A_DISP) begin
            n.rdata[1:0] = s_q.sel;
         end else if (reg_addr == `LCS_A_STAT) begin
            for (int i = 0; i < CN; i++) begin
               n.rdata[i] = (s_q.st[i] == LCS_FAIL);
               n.rdata[CN+i] = (s_q.st[i] == LCS_VER);
               n.rdata[2*CN+i] = s_q.short[i];
               n.rdata[3*CN+i] = s_q.passed[i];
            end
         end else if (reg_addr == `LCS_A_IRQ) begin
            n.rdata[2*CN-1:0] = s_q.stat;
         end else if (reg_addr == `LCS_A_MASK) begin
            n.rdata[2*CN-1:0] = s_q.mask;
         end else if (reg_addr == `LCS_A_MAP) begin
            n.rdata[3*CN-1:0] = {s_q.aux_map, s_q.hlth_map, s_q.det_map};
         end
      end
      s_d = n;
      s_d.vpri = pri_ok;
      s_d.vaux = aux_ok;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_q <= '0;
         for (int i = 0; i < CN; i++) begin
            s_q.st[i] <= LCS_OFF;
         end
         s_q.ival <= `LCS_IVAL_RST;
         // the map reset word covers all three masks, laid out as on a read
         {s_q.aux_map, s_q.hlth_map, s_q.det_map} <= `LCS_MAP_RST;
         s_q.hok <= '1;
         s_q.scr <= LCS_SCR_NONE;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata = s_q.rdata;
   assign check_short = s_q.short;
   assign det_call = s_q.call;
   assign health_ok = s_q.hok;
   assign chan_led = s_q.led;
   assign vital_pri = s_q.vpri;
   assign vital_aux = s_q.vaux;
   assign disp_screen = s_q.scr;
   assign irq = s_q.irq;

   default clocking dc @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence fail_entered(int k);
      s_q.st[k] == LCS_FAIL;
   endsequence

   for (genvar g = 0; g < CN; g++) begin : g_chk
      zero_no_short_a: assert property (reg_wr && reg_addr == `LCS_A_IVAL && reg_wdata[8*g +: 8] == 8'h00
         |=> !check_short[g] && s_q.st[g] == LCS_OFF) else $error("short while off");
      short_needs_ival_a: assert property ($rose(check_short[g]) |-> s_q.ival[g] != 8'h00)
         else $error("short with zero interval");
      pass_ends_short_a: assert property (check_short[g] && meas_valid[g] && !loop_fault[g]
         && meas_mag[16*g +: 16] >= `LCS_PASS_THRESH && !reg_wr |=> !check_short[g] && s_q.stat[g])
         else $error("pass not taken");
      ver_bounded_a: assert property (s_q.st[g] == LCS_VER |-> s_q.cnt[g] <= 14'(`LCS_VERIFY_TICKS))
         else $error("verify too long");
      fail_outputs_a: assert property (fail_entered(g) |-> det_call[g] && !health_ok[g])
         else $error("fail outputs wrong");
      fail_pri_drop_a: assert property (fail_entered(g) && (s_q.det_map[g] || s_q.hlth_map[g]) |-> !vital_pri)
         else $error("primary not dropped");
      fail_aux_drop_a: assert property (fail_entered(g) && s_q.aux_map[g] |-> !vital_aux)
         else $error("aux not dropped");
      chan_reset_clear_a: assert property (reg_wr && reg_addr == `LCS_A_CRST && reg_wdata[g]
         |=> s_q.st[g] != LCS_FAIL) else $error("fail not cleared");
      fault_no_short_a: assert property (loop_fault[g] |=> !check_short[g])
         else $error("check under loop fault");
      boot_check_a: assert property (s_q.st[g] == LCS_BOOT && !loop_fault[g] && s_q.cnt[g] == 14'h0
         && tb.tick && !reg_wr |=> check_short[g]) else $error("boot check missed");
   end
endmodule : lcs_top

// ---- verif/lcs_front_model.sv ----
// front end model: check-loop switch and inductance measurement
// assumes one core clock; measures only while the check loop is shorted
`timescale 1ns/1ps
module lcs_front_model (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [3:0] check_short,
   input wire logic [3:0] good,
   input wire logic [7:0] lat,
   output logic [3:0] meas_valid,
   output logic [63:0] meas_mag
);
   logic [7:0] cnt_q [4];
   logic [15:0] noise_q = 16'h0000;
   always_ff @(posedge core_clk) begin
      noise_q <= noise_q + 16'h1357;
      for (int i = 0; i < 4; i++) begin
         meas_valid[i] <= 1'b0;
         // a stale magnitude never lingers between measurements
         meas_mag[16*i +: 16] <= ~noise_q;
         if (rst || !check_short[i]) begin
            cnt_q[i] <= 8'h00;
         end else if (cnt_q[i] == lat) begin
            cnt_q[i] <= 8'h00;
            meas_valid[i] <= 1'b1;
            meas_mag[16*i +: 16] <= good[i] ? 16'h0028 : 16'h0027;
         end else begin
            cnt_q[i] <= cnt_q[i] + 8'h01;
         end
      end
   end
endmodule : lcs_front_model

// ---- verif/tb_loop_check_supervisor.sv ----
// testbench of the loop check supervisor with a front end model
// assumes rtl files compiled first; tick shortened to 3 cycles
`timescale 1ns/1ps
`include "lcs_cfg.svh"
module tb_loop_check_supervisor import lcs_pkg::*;;
   localparam int T = 3;
   logic core_clk, rst, reg_wr, reg_rd, vital_pri_in, vital_aux_in, vital_pri, vital_aux, irq;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [3:0] loop_fault, meas_valid, det_call_in, check_short, det_call, health_ok, chan_led, good;
   logic [63:0] meas_mag;
   lcs_scr_type disp_screen;
   int failures = 0;
   int num_checks = 0;
   int rises = 0;
   logic prev;
   lcs_top #(.TICK_CYC(T)) dut_u (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .loop_fault(loop_fault), .meas_valid(meas_valid), .meas_mag(meas_mag), .det_call_in(det_call_in),
      .vital_pri_in(vital_pri_in), .vital_aux_in(vital_aux_in), .check_short(check_short),
      .det_call(det_call), .health_ok(health_ok), .chan_led(chan_led), .vital_pri(vital_pri),
      .vital_aux(vital_aux), .disp_screen(disp_screen), .irq(irq));
   lcs_front_model fe_u (.core_clk(core_clk), .rst(rst), .check_short(check_short), .good(good),
      .lat(8'h07), .meas_valid(meas_valid), .meas_mag(meas_mag));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      prev <= check_short[0];
      if (check_short[0] === 1'b1 && prev === 1'b0) begin
         rises <= rises + 1;
      end
   end
   task automatic results;
      if (failures == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : results
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask : chk
   task automatic ticks(input int n);
      repeat (n * T) @(posedge core_clk);
      #1;
   endtask : ticks
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk(what, e, reg_rdata & m);
   endtask : rd_chk
   function automatic logic [2:0] probe(input int w, input int ch);
      case (w)
         0: return {2'b00, check_short[ch]};
         1: return {2'b00, health_ok[ch]};
         2: return {2'b00, meas_valid[ch]};
         3: return {2'b00, chan_led[ch]};
         default: return disp_screen;
      endcase
   endfunction : probe
   task automatic wait_for(input string what, input int w, input int ch, input logic v, input int max_cyc);
      int n;
      n = 0;
      while (probe(w, ch) !== {2'b00, v} && n < max_cyc) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      chk(what, v, probe(w, ch));
   endtask : wait_for
   // first change only aligns; the next two spans give on and off times
   task automatic gap(input string what, input int w, input int ch, input int e);
      logic [2:0] s;
      int n;
      for (int k = 0; k < 3; k++) begin
         s = probe(w, ch);
         n = 0;
         while (probe(w, ch) === s && n < 400) begin
            @(posedge core_clk);
            #1;
            n++;
         end
         if (k > 0) begin
            chk(what, e, n);
         end
      end
   endtask : gap
   task automatic t_reset;
      chk("health_ok", 4'hf, health_ok);
      chk("chan_led", 4'h8, chan_led);
      rd_chk("ival", `LCS_A_IVAL, 32'hffffffff, `LCS_IVAL_RST);
      rd_chk("map", `LCS_A_MAP, 32'hfff, `LCS_MAP_RST);
      wr(`LCS_A_STAT, 32'hffffffff);
      rd_chk("stat ro", `LCS_A_STAT, 32'hffff, 32'h0);
      rd_chk("unmapped", 8'h1c, 32'hffffffff, 32'h0);
      rd_chk("crst wo", `LCS_A_CRST, 32'hffffffff, 32'h0);
      ticks(250);
      chk("short off", 4'h0, check_short);
   endtask : t_reset
   task automatic t_pass;
      @(posedge core_clk);
      loop_fault <= 4'h4;
      wr(`LCS_A_MASK, 32'h33);
      wr(`LCS_A_DISP, 32'h0);
      wr(`LCS_A_IVAL, 32'hff010001);
      ticks(190);
      chk("short early", 4'h0, check_short);
      wait_for("short ch0", 0, 0, 1'b1, 20 * T);
      wait_for("short ch3", 0, 3, 1'b1, 2);
      wait_for("meas ch0", 2, 0, 1'b1, 20);
      @(posedge core_clk);
      #1;
      chk("short ch0 off", 1'b0, check_short[0]);
      chk("pass screen", LCS_SCR_PASS, disp_screen);
      wait_for("short ch3 off", 0, 3, 1'b0, 20);
      chk("short ch2", 1'b0, check_short[2]);
      rd_chk("pass events", `LCS_A_IRQ, 32'hff, 32'h09);
      chk("irq", 1'b1, irq);
      wr(`LCS_A_IRQ, 32'h1);
      ticks(1);
      chk("irq masked", 1'b0, irq);
      rd_chk("passed", `LCS_A_STAT, 32'hf000, 32'h9000);
   endtask : t_pass
   task automatic t_fail;
      wr(`LCS_A_MAP, 32'h202);
      wr(`LCS_A_DISP, 32'h1);
      ticks(1);
      chk("pri before", 1'b1, vital_pri);
      chk("aux before", 1'b1, vital_aux);
      wr(`LCS_A_IVAL, 32'hff000101);
      wait_for("short ch1", 0, 1, 1'b1, 220 * T);
      wait_for("meas ch1", 2, 1, 1'b1, 20);
      ticks(2);
      chk("short held", 1'b1, check_short[1]);
      rd_chk("verifying", `LCS_A_STAT, 32'hf0, 32'h20);
      chk("pending", 1'b1, disp_screen === LCS_SCR_PEND || disp_screen === LCS_SCR_NONE);
      ticks(5400);
      chk("no fail yet", 1'b1, health_ok[1]);
      wait_for("health fail", 1, 1, 1'b0, 200 * T);
      ticks(1);
      chk("call forced", 1'b1, det_call[1]);
      chk("pri dropped", 1'b0, vital_pri);
      chk("aux dropped", 1'b0, vital_aux);
      rd_chk("failed", `LCS_A_STAT, 32'hf, 32'h2);
      rd_chk("fail event", `LCS_A_IRQ, 32'hf0, 32'h20);
      gap("led flash", 3, 1, 16 * T);
      gap("fail screens", 4, 0, 50 * T);
      chk("fail screen", 1'b1, disp_screen === LCS_SCR_FAIL_L || disp_screen === LCS_SCR_FAIL_LC);
   endtask : t_fail
   task automatic t_clear;
      wr(`LCS_A_CRST, 32'h2);
      ticks(2);
      chk("health back", 1'b1, health_ok[1]);
      chk("call back", 1'b0, det_call[1]);
      chk("pri back", 1'b1, vital_pri);
      wait_for("recheck", 0, 1, 1'b1, 220 * T);
      wait_for("meas again", 2, 1, 1'b1, 20);
      ticks(2);
      rd_chk("fails again", `LCS_A_STAT, 32'hf0, 32'h20);
      @(posedge core_clk);
      good <= 4'hf;
      wait_for("restored", 0, 1, 1'b0, 40);
      rd_chk("pass after verify", `LCS_A_STAT, 32'h20f0, 32'h2000);
   endtask : t_clear
   task automatic t_zero;
      @(posedge core_clk);
      good <= 4'hd;
      wr(`LCS_A_CRST, 32'h2);
      wait_for("short ch1", 0, 1, 1'b1, 220 * T);
      wait_for("meas ch1", 2, 1, 1'b1, 20);
      ticks(2);
      wr(`LCS_A_IVAL, 32'hff000001);
      ticks(2);
      chk("zero ends verify", 1'b0, check_short[1]);
      rd_chk("not verifying", `LCS_A_STAT, 32'hf2, 32'h0);
      ticks(250);
      chk("stays off", 1'b0, check_short[1]);
      wr(`LCS_A_IRQ, 32'hff);
      ticks(1);
      chk("irq cleared", 1'b0, irq);
      rd_chk("events cleared", `LCS_A_IRQ, 32'h0f, 32'h0);
   endtask : t_zero
   task automatic t_repeat;
      int n;
      n = 0;
      while (rises < 2 && n < 6200 * T) begin
         @(posedge core_clk);
         n++;
      end
      chk("periodic checks", 2, rises);
   endtask : t_repeat
   initial begin
      rst = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      loop_fault = 4'h0;
      det_call_in = 4'h8;
      vital_pri_in = 1'b1;
      vital_aux_in = 1'b1;
      good = 4'hd;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      #1;
      t_reset();
      t_pass();
      t_fail();
      t_clear();
      t_zero();
      t_repeat();
      results();
   end
   // whole sequence is about 7500 ticks; twice that is a hang
   initial begin
      repeat (15000 * T) @(posedge core_clk);
      failures++;
      results();
   end
endmodule : tb_loop_check_supervisor
